// ### logic/supply_monitor.sv
// supply monitor: enable, high/low supply flags and latched request over APB
`timescale 1ns/1ps
`default_nettype none
module supply_monitor #(
  parameter int SETTLE_CYC = supply_monitor_pkg::SETTLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic aboveUpper,
  input wire logic belowLower,
  output logic monitorOn,
  output logic supplyMonitorRequest
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic enable_r;
  logic lowFlag_r;
  logic highFlag_r;
  logic [supply_monitor_pkg::IRQ_W-1:0] irqReq_r;
  logic [supply_monitor_pkg::IRQ_W-1:0] irqMask_r;
  supply_monitor_pkg::mon_state_t state_r;
  logic settleDone;
  logic enRise;
  logic wrAcc;
  logic [supply_monitor_pkg::IRQ_W-1:0] clrReq;

  // bus decode
  logic setupPhase;
  logic selCtrl;
  logic selReq;
  logic selMask;
  logic selClr;
  logic selStat;
  logic selHit;

  // request plumbing
  logic lowEvent;
  logic flagsLive;
  logic [supply_monitor_pkg::IRQ_W-1:0] setReq;
  logic irqLine_nxt;

  // read views
  logic [supply_monitor_pkg::REG_W-1:0] ctrlView;
  logic [supply_monitor_pkg::REG_W-1:0] reqView;
  logic [supply_monitor_pkg::REG_W-1:0] maskView;
  logic [supply_monitor_pkg::REG_W-1:0] statView;
  logic [31:0] rdWord;
  logic missErr;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // one select per register, so each process below tests a select, not an address
  always_comb begin
    selCtrl = 1'b0;
    selReq = 1'b0;
    selMask = 1'b0;
    selClr = 1'b0;
    selStat = 1'b0;
    if (paddr == supply_monitor_pkg::VD_CTRL_ADDR) begin
      selCtrl = 1'b1;
    end else if (paddr == supply_monitor_pkg::IRQ_REQ_ADDR) begin
      selReq = 1'b1;
    end else if (paddr == supply_monitor_pkg::IRQ_MASK_ADDR) begin
      selMask = 1'b1;
    end else if (paddr == supply_monitor_pkg::IRQ_CLR_ADDR) begin
      selClr = 1'b1;
    end else if (paddr == supply_monitor_pkg::VD_STAT_ADDR) begin
      selStat = 1'b1;
    end
  end

  // a miss answers with a slave error and reads zero
  assign selHit = selCtrl || selReq || selMask || selClr || selStat;

  // writes land in the access phase; read data is frozen in the setup phase
  assign setupPhase = psel && !penable;
  assign wrAcc = psel && penable && pready && pwrite;
  // only a rising enable restarts the settle timer; rewriting one keeps the count
  assign enRise = wrAcc && selCtrl && pwdata[supply_monitor_pkg::VD_EN_BIT] && !enable_r;
  // write one to clear; zero bits leave their request alone
  assign clrReq = (wrAcc && selClr) ? pwdata[supply_monitor_pkg::IRQ_W-1:0] : '0;

  // ****************************************************************
  // request sources
  // ****************************************************************
  // only source 5 has an event in this block; the other request bits never set
  always_comb begin
    setReq = '0;
    setReq[supply_monitor_pkg::REQ_SRC_BIT] = lowEvent;
  end

  // a low flag counts only while monitoring is on
  assign lowEvent = lowFlag_r && enable_r;
  // flags may follow the comparators only once settled and still enabled
  assign flagsLive = (state_r == supply_monitor_pkg::MON_LIVE) && enable_r;

  // ****************************************************************
  // control registers
  // ****************************************************************
  // only the enable bit is writable; flag and reserved bits drop writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= supply_monitor_pkg::CTRL_RST[supply_monitor_pkg::VD_EN_BIT];
    end else if (wrAcc && selCtrl) begin
      enable_r <= pwdata[supply_monitor_pkg::VD_EN_BIT];
    end
  end

  // mask register steers the interrupt output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqMask_r <= supply_monitor_pkg::IRQ_RST;
    end else if (wrAcc && selMask) begin
      irqMask_r <= pwdata[supply_monitor_pkg::IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // settle sequencing
  // ****************************************************************
  settle_timer #(
    .CNT_W(supply_monitor_pkg::CNT_W),
    .LIMIT(supply_monitor_pkg::CNT_W'(SETTLE_CYC - 1))
  ) u_settle (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(enRise),
    .run(enable_r),
    .done(settleDone)
  );

  // off -> settle -> live; dropping the enable returns to off at once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= supply_monitor_pkg::MON_OFF;
    end else begin
      case (state_r)
        supply_monitor_pkg::MON_OFF: begin
          if (enable_r) begin
            state_r <= supply_monitor_pkg::MON_SETTLE;
          end
        end
        supply_monitor_pkg::MON_SETTLE: begin
          if (!enable_r) begin
            state_r <= supply_monitor_pkg::MON_OFF;
          end else if (settleDone) begin
            state_r <= supply_monitor_pkg::MON_LIVE;
          end
        end
        supply_monitor_pkg::MON_LIVE: begin
          if (!enable_r) begin
            state_r <= supply_monitor_pkg::MON_OFF;
          end
        end
        default: begin
          state_r <= supply_monitor_pkg::MON_OFF;
        end
      endcase
    end
  end

  // ****************************************************************
  // flags
  // ****************************************************************
  // flags track the comparators each cycle once settled; zero otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowFlag_r <= 1'b0;
      highFlag_r <= 1'b0;
    end else if (flagsLive) begin
      lowFlag_r <= belowLower;
      highFlag_r <= aboveUpper;
    end else begin
      lowFlag_r <= 1'b0;
      highFlag_r <= 1'b0;
    end
  end

  // request latch: set wins over a same-cycle clear so no event is lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqReq_r <= supply_monitor_pkg::IRQ_RST;
    end else begin
      for (int i = 0; i < supply_monitor_pkg::IRQ_W; i++) begin
        if (setReq[i]) begin
          irqReq_r[i] <= 1'b1;
        end else if (clrReq[i]) begin
          irqReq_r[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // masked request drives the interrupt line; a bit with its mask clear stays pollable only
  assign irqLine_nxt = |(irqReq_r & irqMask_r);

  // interrupt line is registered so the pin comes straight from a flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      supplyMonitorRequest <= 1'b0;
    end else begin
      supplyMonitorRequest <= irqLine_nxt;
    end
  end

  // monitorOn mirrors the enable bit one cycle late
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      monitorOn <= 1'b0;
    end else begin
      monitorOn <= enable_r;
    end
  end

  // ****************************************************************
  // register read views
  // ****************************************************************
  // views are built bit by bit so reserved bits read as zero by construction
  always_comb begin
    ctrlView = '0;
    ctrlView[supply_monitor_pkg::VD_EN_BIT] = enable_r;
    ctrlView[supply_monitor_pkg::LOW_FLAG_BIT] = lowFlag_r;
    ctrlView[supply_monitor_pkg::HIGH_FLAG_BIT] = highFlag_r;
  end

  // request and mask are six bits wide; the upper view bits stay zero
  always_comb begin
    reqView = '0;
    maskView = '0;
    reqView[supply_monitor_pkg::IRQ_W-1:0] = irqReq_r;
    maskView[supply_monitor_pkg::IRQ_W-1:0] = irqMask_r;
  end

  // the valid bit tells software when the flags may be trusted
  always_comb begin
    statView = '0;
    statView[supply_monitor_pkg::VALID_BIT] = (state_r == supply_monitor_pkg::MON_LIVE);
  end

  // read mux: the clear register reads zero, a miss reads zero with an error
  always_comb begin
    rdWord = 32'h0000_0000;
    missErr = 1'b0;
    if (selCtrl) begin
      rdWord[supply_monitor_pkg::REG_W-1:0] = ctrlView;
    end else if (selReq) begin
      rdWord[supply_monitor_pkg::REG_W-1:0] = reqView;
    end else if (selMask) begin
      rdWord[supply_monitor_pkg::REG_W-1:0] = maskView;
    end else if (selStat) begin
      rdWord[supply_monitor_pkg::REG_W-1:0] = statView;
    end else if (!selHit) begin
      missErr = 1'b1;
    end
  end

  // ****************************************************************
  // apb slave: zero wait states, unmapped reads zero with an error
  // ****************************************************************
  // answer in the cycle after setup on every access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setupPhase;
    end
  end

  // word and error frozen at setup so a read cannot tear; idle cycles read zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setupPhase) begin
      pslverr <= missErr;
      prdata <= rdWord;
    end else begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end
endmodule // supply_monitor
`default_nettype wire

// ### logic/supply_monitor_pkg.sv
// package: register map, field positions, reset values and timing for the supply monitor
package supply_monitor_pkg;
  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [11:0] VD_CTRL_ADDR = 12'h00C;   // voltage_detect_ctrl
  localparam logic [11:0] IRQ_REQ_ADDR = 12'h010;   // interrupt request register
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h014;  // interrupt_mask_reg
  localparam logic [11:0] IRQ_CLR_ADDR = 12'h018;   // write one to clear request bits
  localparam logic [11:0] VD_STAT_ADDR = 12'h01C;   // flags-valid and settle status

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int VD_EN_BIT = 0;
  localparam int LOW_FLAG_BIT = 1;
  localparam int HIGH_FLAG_BIT = 2;
  localparam int REQ_SRC_BIT = 5;        // supply_monitor_request source number
  localparam int VALID_BIT = 0;
  localparam int IRQ_W = 6;
  localparam int REG_W = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] IRQ_RST = 6'h00;

  // ****************************************************************
  // timing: flags settle 20 us after enable
  // ****************************************************************
  localparam int CLK_HZ = 20000000;
  localparam int SETTLE_NS = 20000;
  localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CNT_W = 12;

  typedef enum logic [1:0] {
    MON_OFF = 2'b00,
    MON_SETTLE = 2'b01,
    MON_LIVE = 2'b10
  } mon_state_t;
endpackage : supply_monitor_pkg

// ### logic/settle_timer.sv
// settle timer: counts the flag settling time after monitoring is switched on
`timescale 1ns/1ps
`default_nettype none
module settle_timer #(
  parameter int CNT_W = 12,
  parameter logic [CNT_W-1:0] LIMIT = CNT_W'(supply_monitor_pkg::SETTLE_CYC - 1)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic run,
  output logic done
);
  logic [CNT_W-1:0] count_r;

  // counts while run holds; start reloads so a re-enable gets a full settle time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (start || !run) begin
      count_r <= '0;
    end else if (count_r != LIMIT) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign done = run && !start && (count_r == LIMIT);
endmodule // settle_timer
`default_nettype wire

// ### bench/supply_monitor_monitor.sv
// checker: port-level assertions on the supply monitor
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_monitor #(
  parameter int SETTLE_CYC = supply_monitor_pkg::SETTLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic aboveUpper,
  input wire logic belowLower,
  input wire logic monitorOn,
  input wire logic supplyMonitorRequest
);
  // ****************************************************************
  // helper decode and enable-age counter
  // ****************************************************************
  wire logic acc = psel && penable && pready;
  wire logic ctrlRd = acc && !pwrite && paddr == 12'h00C;
  wire logic ctrlWr = acc && pwrite && paddr == 12'h00C;
  wire logic maskWr = acc && pwrite && paddr == 12'h014;
  wire logic clrWr = acc && pwrite && paddr == 12'h018;
  wire logic [1:0] cmp = {aboveUpper, belowLower};
  logic [15:0] onCnt_r;
  // age of monitoring; wide enough for the full settle time and saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) onCnt_r <= 16'h0000;
    else if (!monitorOn) onCnt_r <= 16'h0000;
    else if (onCnt_r != 16'hFFFF) onCnt_r <= onCnt_r + 16'h0001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  zero_wait_a: assert property ((psel && !penable) |=> pready)
    else $error("access phase not answered at once");
  settle_quiet_a: assert property (
    (ctrlRd && onCnt_r + 2 < SETTLE_CYC) |-> prdata[2:1] == 2'b00) else $error("flags early");
  upper_zero_a: assert property (ctrlRd |-> prdata[31:3] == 29'h0)
    else $error("reserved bits not zero");
  flag_track_a: assert property (
    (ctrlRd && onCnt_r > SETTLE_CYC + 4 && $past(cmp) == cmp && $past(cmp, 2) == cmp
      && $past(cmp, 3) == cmp) |-> prdata[2:1] == cmp) else $error("flags not tracking");
  err_map_a: assert property ((psel && pready) |-> pslverr == !(paddr inside
    {12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C})) else $error("slave error misplaced");
  req_rise_a: assert property (
    $rose(supplyMonitorRequest) |-> monitorOn || $past(monitorOn) || $past(maskWr)
      || $past(maskWr, 2))
    else $error("request raised without cause");
  req_hold_a: assert property (
    $fell(supplyMonitorRequest) |-> $past(clrWr) || $past(clrWr, 2) || $past(maskWr)
      || $past(maskWr, 2)) else $error("request dropped without clear");
  enable_follow_a: assert property (
    $changed(monitorOn) |-> $past(ctrlWr) || $past(ctrlWr, 2)) else $error("enable moved alone");
endmodule // supply_monitor_monitor
`default_nettype wire

// ### bench/supply_rail_model.sv
// partner: comparator pair watching a modelled supply rail
`timescale 1ns/1ps
`default_nettype none
module supply_rail_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] railLevel,
  output logic aboveUpper,
  output logic belowLower
);
  // level 1 is a sag, 2 a surge; one rail can never be both at once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aboveUpper <= 1'b0;
      belowLower <= 1'b0;
    end else begin
      aboveUpper <= railLevel == 2'h2;
      belowLower <= railLevel == 2'h1;
    end
  end
endmodule // supply_rail_model
`default_nettype wire

// ### bench/testbench.sv
// testbench: register-level tests of the supply monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SETTLE_CYC = 8;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, aboveUpper, belowLower, monitorOn, supplyMonitorRequest, err;
  logic [1:0] railLevel = 2'h0;
  int fails = 0, num_checks = 0, cycles = 0;
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  supply_monitor #(.SETTLE_CYC(SETTLE_CYC)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .aboveUpper(aboveUpper),
    .belowLower(belowLower), .monitorOn(monitorOn), .supplyMonitorRequest(supplyMonitorRequest));
  supply_rail_model u_rail (.core_clk(core_clk), .rst_n(rst_n), .railLevel(railLevel),
    .aboveUpper(aboveUpper), .belowLower(belowLower));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  // one apb transfer; an edge always passes before a new setup
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // hang guard well above the hundred-odd cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk("ctrl", 12'h00C, 32'h0);
    rdchk("request", 12'h010, 32'h0);
    $display("test reset values done");
    railLevel <= 2'h2;
    xfer(1'b1, 12'h00C, 32'hFF);
    rdchk("ctrl settling", 12'h00C, 32'h1);
    chk("monitorOn", 32'h1, {31'h0, monitorOn});
    rdchk("status settling", 12'h01C, 32'h0);
    repeat (SETTLE_CYC + 4) @(posedge core_clk);
    rdchk("ctrl surge", 12'h00C, 32'h5);
    rdchk("status live", 12'h01C, 32'h1);
    railLevel <= 2'h1;
    repeat (4) @(posedge core_clk);
    rdchk("ctrl sag", 12'h00C, 32'h3);
    rdchk("request sag", 12'h010, 32'h20);
    chk("irq masked", 32'h0, {31'h0, supplyMonitorRequest});
    railLevel <= 2'h0;
    repeat (4) @(posedge core_clk);
    rdchk("request held", 12'h010, 32'h20);
    rdchk("ctrl nominal", 12'h00C, 32'h1);
    $display("test flags done");
    xfer(1'b1, 12'h014, 32'h20);
    rdchk("mask", 12'h014, 32'h20);
    repeat (3) @(posedge core_clk);
    chk("irq unmasked", 32'h1, {31'h0, supplyMonitorRequest});
    xfer(1'b1, 12'h018, 32'h20);
    repeat (3) @(posedge core_clk);
    rdchk("request cleared", 12'h010, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, supplyMonitorRequest});
    xfer(1'b0, 12'h040, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test request done");
    xfer(1'b1, 12'h00C, 32'h0);
    railLevel <= 2'h1;
    repeat (6) @(posedge core_clk);
    rdchk("ctrl off", 12'h00C, 32'h0);
    rdchk("request off", 12'h010, 32'h0);
    xfer(1'b1, 12'h00C, 32'h1);
    repeat (SETTLE_CYC + 6) @(posedge core_clk);
    chk("irq power-up sag", 32'h1, {31'h0, supplyMonitorRequest});
    $display("test disable and power-up done");
    tally_and_finish;
  end
endmodule // testbench
bind supply_monitor supply_monitor_monitor #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .aboveUpper(aboveUpper), .belowLower(belowLower), .monitorOn(monitorOn),
  .supplyMonitorRequest(supplyMonitorRequest));
`default_nettype wire
